// ### core/kkil_map.svh
// Register offsets, field positions, reset values and key codes
`ifndef KKIL_MAP_SVH
`define KKIL_MAP_SVH
// ==========================================================
// Register byte addresses
`define KKIL_CTRL_OFF 12'h000
`define KKIL_STAT_OFF 12'h004
// ==========================================================
// Control register fields
`define KKIL_CTRL_LOCKALL 0
`define KKIL_CTRL_CLICK 1
`define KKIL_CTRL_MBELL 2
`define KKIL_CTRL_CRLF 3
`define KKIL_CTRL_BRKEN 4
`define KKIL_CTRL_MODE_LO 5
`define KKIL_CTRL_MODE_HI 6
`define KKIL_CTRL_W 7
`define KKIL_CTRL_RST 7'h06
// ==========================================================
// Special key identifiers (bit 7 set marks a function key)
`define KKIL_K_SHIFT 8'h80
`define KKIL_K_CTRL 8'h81
`define KKIL_K_LOCK 8'h82
`define KKIL_K_FREEZE 8'h83
`define KKIL_K_SETUP 8'h84
`define KKIL_K_COMPOSE 8'h85
`define KKIL_K_BREAK 8'h86
`define KKIL_K_PRINT 8'h87
`define KKIL_K_ERASE 8'h88
`define KKIL_K_RETURN 8'h89
`define KKIL_K_ENTER 8'h8A
`define KKIL_K_F11 8'h8B
`define KKIL_K_F12 8'h8C
`define KKIL_K_F13 8'h8D
`define KKIL_K_HANDOVER 8'h8E
`define KKIL_K_APP_BASE 8'hC0
// ==========================================================
// Character codes
`define KKIL_C_BS 8'h08
`define KKIL_C_BEL 8'h07
`define KKIL_C_LF 8'h0A
`define KKIL_C_CR 8'h0D
`define KKIL_C_CAN 8'h18
`define KKIL_C_ESC 8'h1B
`define KKIL_C_DEL 8'h7F
`define KKIL_C_CTLMASK 8'h1F
`endif

// ### core/kkil_pkg.sv
// Types shared by the key and indicator logic
`default_nettype none
package kkil_pkg;
  // Terminal operating modes
  typedef enum logic [1:0] {
    KKIL_LEGACY_ANSI_MODE = 2'h0,
    KKIL_LEGACY_PRIVATE_MODE = 2'h1,
    KKIL_EXTENDED_MODE_7 = 2'h2,
    KKIL_EXTENDED_MODE_8 = 2'h3
  } kkil_mode_t;
  // Compose sequence states, one-hot
  typedef enum logic [2:0] {
    KKIL_CMP_IDLE = 3'b001,
    KKIL_CMP_FIRST = 3'b010,
    KKIL_CMP_SECOND = 3'b100
  } kkil_cmp_t;
endpackage
`default_nettype wire

// ### core/kkil_keys.sv
// Keyboard key handling, lamps, keyclick and bell control
`timescale 1ns/1ps
`default_nettype none
`include "kkil_map.svh"
module kkil_keys
  import kkil_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic key_stb,
  input wire logic key_make,
  input wire logic [7:0] key_id,
  input wire logic host_stb,
  input wire logic [7:0] host_char,
  input wire logic margin_stb,
  input wire logic host_block_pin,
  output var logic lamp_lock,
  output var logic lamp_freeze,
  output var logic lamp_compose,
  output var logic lamp_wait,
  output var logic click_pulse,
  output var logic bell_pulse,
  output var logic tx_stb,
  output var logic [7:0] tx_code,
  output var logic tx_local,
  output var logic break_req,
  output var logic disc_req,
  output var logic answer_req,
  output var logic print_text_req,
  output var logic print_image_req,
  output var logic handover_req,
  output var logic autoprint,
  output var logic setup_state,
  output var logic host_hold,
  output var logic show_stb,
  output var logic [7:0] show_char
);

  // ==========================================================
  // Helper functions
  function automatic logic is_letter(input logic [7:0] c);
    is_letter = (c >= 8'h61) && (c <= 8'h7A);
  endfunction

  // Shifted value of an unshifted key character
  function automatic logic [7:0] shifted(input logic [7:0] c);
    if (is_letter(c)) begin
      shifted = c - 8'h20;
    end else if (c == 8'h31) begin
      shifted = 8'h21;
    end else if (c == 8'h2C || c == 8'h2E || c == 8'h2F) begin
      shifted = c + 8'h10;
    end else if (c == 8'h3B) begin
      shifted = 8'h3A;
    end else begin
      shifted = c;
    end
  endfunction

  // ==========================================================
  // Registers and state
  logic [`KKIL_CTRL_W-1:0] ctrl_q;
  logic lock_q, freeze_q, setup_q, autoprint_q, shift_q, ctl_q;
  logic blk_s1_q, blk_s2_q, wait_q, boot_q;
  kkil_cmp_t cmp_q;
  logic [7:0] cmp_ch_q;
  logic lf_pend_q;
  kkil_mode_t mode;
  logic acc, press;

  assign mode = kkil_mode_t'(ctrl_q[`KKIL_CTRL_MODE_HI:`KKIL_CTRL_MODE_LO]);
  assign acc = psel && penable && !pready;
  assign press = key_stb && key_make;

  // ==========================================================
  // APB slave, one wait state on every access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (acc) begin
        if (paddr == `KKIL_CTRL_OFF) begin
          prdata <= {25'h0000000, ctrl_q};
        end else if (paddr == `KKIL_STAT_OFF) begin
          prdata <= {26'h0000000, autoprint_q, setup_q, wait_q,
                     lamp_compose, freeze_q, lock_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Control register write lands on the completing edge, with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `KKIL_CTRL_RST;
    end else if (psel && penable && pready && pwrite
                 && paddr == `KKIL_CTRL_OFF) begin
      ctrl_q <= pwdata[`KKIL_CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Blocked-link pin synchroniser and wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      blk_s1_q <= host_block_pin;
      blk_s2_q <= blk_s1_q;
      wait_q <= blk_s2_q;
    end
  end

  // ==========================================================
  // Modifier tracking on press and release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 1'b0;
      ctl_q <= 1'b0;
    end else if (key_stb) begin
      if (key_id == `KKIL_K_SHIFT) shift_q <= key_make;
      if (key_id == `KKIL_K_CTRL) ctl_q <= key_make;
    end
  end

  // Toggle states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      freeze_q <= 1'b0;
      setup_q <= 1'b0;
      autoprint_q <= 1'b0;
    end else if (press) begin
      if (key_id == `KKIL_K_LOCK) lock_q <= !lock_q;
      if (key_id == `KKIL_K_FREEZE) freeze_q <= !freeze_q;
      if (key_id == `KKIL_K_SETUP) setup_q <= !setup_q;
      if (key_id == `KKIL_K_PRINT && ctl_q && !shift_q) begin
        autoprint_q <= !autoprint_q;
      end
    end
  end

  // ==========================================================
  // Key decode into character and request pulses
  logic k_fn, k_inact, k_click, k_send, k_lf, c_err, c_done;
  logic [7:0] k_ch, k_code;
  logic k_brk, k_disc, k_ans, k_ptxt, k_pimg;
  always_comb begin
    k_fn = key_id[7];
    k_inact = k_fn && (key_id > `KKIL_K_HANDOVER)
              && (key_id < `KKIL_K_APP_BASE);
    k_ch = key_id;
    k_code = 8'h00;
    k_send = 1'b0;
    k_lf = 1'b0;
    k_brk = 1'b0;
    k_disc = 1'b0;
    k_ans = 1'b0;
    k_ptxt = 1'b0;
    k_pimg = 1'b0;
    c_err = 1'b0;
    c_done = 1'b0;
    // Modifiers, waiting, disabling and inactive keys stay silent
    k_click = press && key_id != `KKIL_K_SHIFT && key_id != `KKIL_K_CTRL
              && !wait_q && ctrl_q[`KKIL_CTRL_CLICK] && !k_inact;
    if (shift_q || (lock_q && ctrl_q[`KKIL_CTRL_LOCKALL])) begin
      k_ch = shifted(key_id);
    end else if (lock_q && is_letter(key_id)) begin
      k_ch = key_id - 8'h20;
    end
    if (ctl_q) k_ch = k_ch & `KKIL_C_CTLMASK;
    if (press && !k_fn) begin
      if (cmp_q == KKIL_CMP_FIRST) begin
        k_send = 1'b0;
      end else if (cmp_q == KKIL_CMP_SECOND) begin
        // Equal pair is not a valid compose
        c_done = 1'b1;
        c_err = (cmp_ch_q == key_id);
        k_send = !c_err;
        k_code = 8'h80 | (cmp_ch_q ^ key_id);
      end else begin
        k_send = 1'b1;
        k_code = k_ch;
      end
    end else if (press) begin
      case (key_id)
        `KKIL_K_ERASE: begin
          k_send = 1'b1;
          k_code = shift_q ? `KKIL_C_CAN : `KKIL_C_DEL;
        end
        `KKIL_K_RETURN, `KKIL_K_ENTER: begin
          k_send = 1'b1;
          k_code = `KKIL_C_CR;
          k_lf = ctrl_q[`KKIL_CTRL_CRLF];
        end
        `KKIL_K_F11, `KKIL_K_F12, `KKIL_K_F13: begin
          k_send = 1'b1;
          if (mode == KKIL_LEGACY_ANSI_MODE ||
              mode == KKIL_LEGACY_PRIVATE_MODE) begin
            if (key_id == `KKIL_K_F11) k_code = `KKIL_C_ESC;
            else if (key_id == `KKIL_K_F12) k_code = `KKIL_C_BS;
            else k_code = `KKIL_C_LF;
          end else begin
            k_code = key_id;
          end
        end
        `KKIL_K_BREAK: begin
          k_disc = shift_q;
          k_ans = ctl_q && !shift_q;
          k_brk = !shift_q && !ctl_q && ctrl_q[`KKIL_CTRL_BRKEN];
        end
        `KKIL_K_PRINT: begin
          k_pimg = shift_q && !ctl_q;
          k_ptxt = !shift_q && !ctl_q;
        end
        default: begin
          if (key_id >= `KKIL_K_APP_BASE) begin
            k_send = 1'b1;
            k_code = key_id;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Compose sequence state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_q <= KKIL_CMP_IDLE;
      cmp_ch_q <= 8'h00;
    end else if (press) begin
      case (cmp_q)
        KKIL_CMP_IDLE: begin
          if (key_id == `KKIL_K_COMPOSE) cmp_q <= KKIL_CMP_FIRST;
        end
        KKIL_CMP_FIRST: begin
          if (!k_fn) begin
            cmp_ch_q <= key_id;
            cmp_q <= KKIL_CMP_SECOND;
          end
        end
        KKIL_CMP_SECOND: begin
          if (c_done) cmp_q <= KKIL_CMP_IDLE;
        end
        default: cmp_q <= KKIL_CMP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Transmit path; keys typed while waiting are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stb <= 1'b0;
      tx_code <= 8'h00;
      tx_local <= 1'b0;
      lf_pend_q <= 1'b0;
    end else begin
      tx_stb <= 1'b0;
      lf_pend_q <= 1'b0;
      tx_local <= setup_q;
      if (lf_pend_q) begin
        tx_stb <= 1'b1;
        tx_code <= `KKIL_C_LF;
      end else if (k_send && !wait_q) begin
        tx_stb <= 1'b1;
        tx_code <= k_code;
        lf_pend_q <= k_lf;
      end
    end
  end

  // Request pulses for break, print and line handover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_req <= 1'b0;
      disc_req <= 1'b0;
      answer_req <= 1'b0;
      print_text_req <= 1'b0;
      print_image_req <= 1'b0;
      handover_req <= 1'b0;
    end else begin
      break_req <= k_brk && !wait_q;
      disc_req <= k_disc;
      answer_req <= k_ans && !wait_q;
      print_text_req <= k_ptxt;
      print_image_req <= k_pimg;
      handover_req <= press && key_id == `KKIL_K_HANDOVER;
    end
  end

  // ==========================================================
  // Click and bell pulses; bell once after reset for self-test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b1;
      click_pulse <= 1'b0;
      bell_pulse <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      click_pulse <= k_click;
      bell_pulse <= boot_q
                    || (host_stb && host_char == `KKIL_C_BEL)
                    || (press && c_err)
                    || (margin_stb && ctrl_q[`KKIL_CTRL_MBELL]);
    end
  end

  // ==========================================================
  // Host characters to the screen unless frozen or configuring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_stb <= 1'b0;
      show_char <= 8'h00;
      host_hold <= 1'b0;
    end else begin
      show_stb <= host_stb && !freeze_q && !setup_q;
      if (host_stb) show_char <= host_char;
      host_hold <= setup_q;
    end
  end

  // Lamps and state outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_lock <= 1'b0;
      lamp_freeze <= 1'b0;
      lamp_compose <= 1'b0;
      lamp_wait <= 1'b0;
      autoprint <= 1'b0;
      setup_state <= 1'b0;
    end else begin
      lamp_lock <= lock_q;
      lamp_freeze <= freeze_q;
      lamp_compose <= cmp_q != KKIL_CMP_IDLE;
      lamp_wait <= wait_q;
      autoprint <= autoprint_q;
      setup_state <= setup_q;
    end
  end

  // ==========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_lamp_a: assert property ($changed(lock_q) |=> lamp_lock == lock_q)
    else $error("lock lamp does not follow lock state");
  freeze_lamp_a: assert property (lamp_freeze == $past(freeze_q))
    else $error("freeze lamp does not follow freeze state");
  compose_lamp_a: assert property (
    press && cmp_q == KKIL_CMP_IDLE && key_id == `KKIL_K_COMPOSE
    |=> ##1 lamp_compose)
    else $error("compose lamp not lit after compose key");
  wait_lamp_a: assert property (
    host_block_pin [*4] |=> lamp_wait)
    else $error("wait lamp missing while link blocked");
  modifier_click_a: assert property (
    key_stb && (key_id == `KKIL_K_SHIFT || key_id == `KKIL_K_CTRL)
    |=> !click_pulse)
    else $error("click on modifier key");
  wait_click_a: assert property (wait_q |=> !click_pulse && !tx_stb
    || $past(lf_pend_q))
    else $error("click or send while waiting");
  erase_code_a: assert property (
    press && key_id == `KKIL_K_ERASE && !wait_q && !lf_pend_q
    |=> tx_stb && tx_code == ($past(shift_q) ? 8'h18 : 8'h7F))
    else $error("erase key code wrong");
  crlf_seq_a: assert property (
    tx_stb && tx_code == `KKIL_C_CR && lf_pend_q
    |=> tx_stb && tx_code == `KKIL_C_LF)
    else $error("line feed missing after return");
  host_bell_a: assert property (
    host_stb && host_char == `KKIL_C_BEL |=> bell_pulse)
    else $error("host bell not sounded");
  frozen_show_a: assert property (freeze_q |=> !show_stb)
    else $error("character shown while frozen");

  return_cov: cover property (press && key_id == `KKIL_K_RETURN
    ##1 tx_stb ##1 tx_stb);
  compose_cov: cover property (lamp_compose ##[1:50] !lamp_compose);
  freeze_cov: cover property (host_stb && freeze_q);

endmodule
`default_nettype wire

// ### testbench/kkil_far_end.sv
// Far-end model: main controller sending host characters and wait level
`timescale 1ns/1ps
`default_nettype none
module kkil_far_end (
  input wire logic pclk,
  input wire logic tx_stb,
  input wire logic [7:0] tx_code,
  output var logic host_stb,
  output var logic [7:0] host_char,
  output var logic margin_stb,
  output var logic host_block_pin
);
  logic [7:0] rx_q[$];
  // ==========================================================
  // Receive side
  // Collect every code the keyboard sends
  always @(posedge pclk) begin
    if (tx_stb === 1'b1) begin
      rx_q.push_back(tx_code);
    end
  end
  // ==========================================================
  // Send side
  // Idle levels at time zero
  initial begin
    host_stb = 1'b0;
    host_char = 8'h00;
    margin_stb = 1'b0;
    host_block_pin = 1'b0;
  end
  // One character; line scrambled once the strobe drops
  task automatic send(input logic [7:0] ch, input int gap);
    @(posedge pclk);
    host_stb <= 1'b1;
    host_char <= ch;
    @(posedge pclk);
    host_stb <= 1'b0;
    host_char <= ~ch;
    repeat (gap) @(posedge pclk);
  endtask
  // Cursor nears the right margin
  task automatic margin();
    @(posedge pclk);
    margin_stb <= 1'b1;
    @(posedge pclk);
    margin_stb <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // Block or free the keyboard, then let the synchroniser settle
  task automatic set_block(input logic lvl);
    @(posedge pclk);
    host_block_pin <= lvl;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the key and indicator logic
`timescale 1ns/1ps
`default_nettype none
`include "kkil_map.svh"
module tb_top;
  import kkil_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic key_stb, key_make, host_stb, margin_stb, host_block_pin;
  logic [7:0] key_id, host_char, tx_code, show_char;
  logic lamp_lock, lamp_freeze, lamp_compose, lamp_wait, click_pulse;
  logic bell_pulse, tx_stb, tx_local, break_req, disc_req, answer_req;
  logic print_text_req, print_image_req, handover_req, autoprint;
  logic setup_state, host_hold, show_stb;
  wire logic [8:0] pls;
  int cnt[9];
  int error_cnt, checks_done, m, j;
  logic [31:0] rd;
  logic er;
  logic [7:0] lg[3] = '{`KKIL_C_ESC, `KKIL_C_BS, `KKIL_C_LF};
  // ==========================================================
  // Instances
  kkil_keys dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_stb(key_stb), .key_make(key_make), .key_id(key_id),
    .host_stb(host_stb), .host_char(host_char), .margin_stb(margin_stb),
    .host_block_pin(host_block_pin), .lamp_lock(lamp_lock),
    .lamp_freeze(lamp_freeze), .lamp_compose(lamp_compose),
    .lamp_wait(lamp_wait), .click_pulse(click_pulse),
    .bell_pulse(bell_pulse), .tx_stb(tx_stb), .tx_code(tx_code),
    .tx_local(tx_local), .break_req(break_req), .disc_req(disc_req),
    .answer_req(answer_req), .print_text_req(print_text_req),
    .print_image_req(print_image_req), .handover_req(handover_req),
    .autoprint(autoprint), .setup_state(setup_state),
    .host_hold(host_hold), .show_stb(show_stb), .show_char(show_char));
  kkil_far_end far_u (.pclk(pclk), .tx_stb(tx_stb), .tx_code(tx_code),
    .host_stb(host_stb), .host_char(host_char), .margin_stb(margin_stb),
    .host_block_pin(host_block_pin));
  // ==========================================================
  // Clock and pulse counters
  always #10 pclk = ~pclk;
  assign pls = {handover_req, print_image_req, print_text_req, answer_req,
    disc_req, break_req, show_stb, bell_pulse, click_pulse};
  // Count each one-cycle pulse: 0 click 1 bell 2 show 3 break 4 disc
  always @(posedge pclk) begin
    for (int i = 0; i < 9; i++) begin
      if (pls[i] === 1'b1) cnt[i]++;
    end
  end
  // ==========================================================
  // Tasks
  task automatic ck(input string nm, input logic [31:0] e,
                    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One key event, then time for the answer and lamp update
  task automatic key(input logic [7:0] id, input logic mk);
    @(posedge pclk);
    key_stb <= 1'b1;
    key_make <= mk;
    key_id <= id;
    @(posedge pclk);
    key_stb <= 1'b0;
    key_id <= ~id;
    repeat (4) @(posedge pclk);
  endtask
  task automatic clr();
    cnt = '{default: 0};
    far_u.rx_q.delete();
  endtask
  task automatic ck_tx(input int i, input logic [7:0] e);
    ck("tx_code", {24'h0, e}, {24'h0, far_u.rx_q[i]});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; key_stb = 0; key_make = 0; key_id = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    ck("self_test_bell", 1, cnt[1]);
    apb(0, `KKIL_CTRL_OFF, 0);
    ck("ctrl_reset", 32'h06, rd);
    apb(0, `KKIL_STAT_OFF, 0);
    ck("stat_reset", 0, rd);
    apb(0, 12'h010, 0);
    ck("unmapped_err", 1, er);
    // Extended mode, click and margin bell on
    apb(1, `KKIL_CTRL_OFF, 32'h46);
    apb(0, `KKIL_CTRL_OFF, 0);
    ck("ctrl_rw", 32'h46, rd);
    clr();
    key(8'h61, 1); key(`KKIL_K_SHIFT, 1); key(8'h61, 1);
    key(`KKIL_K_ERASE, 1); key(`KKIL_K_SHIFT, 0); key(`KKIL_K_CTRL, 1);
    key(8'h61, 1); key(`KKIL_K_CTRL, 0); key(`KKIL_K_ERASE, 1);
    ck("click_count", 5, cnt[0]);
    ck("tx_count", 5, far_u.rx_q.size());
    ck_tx(0, 8'h61);
    ck_tx(1, 8'h41);
    ck_tx(2, `KKIL_C_CAN);
    ck_tx(3, 8'h01);
    ck_tx(4, `KKIL_C_DEL);
    // Return alone, then return and enter with line feed added
    clr();
    key(`KKIL_K_RETURN, 1);
    apb(1, `KKIL_CTRL_OFF, 32'h4E);
    key(`KKIL_K_RETURN, 1); key(`KKIL_K_ENTER, 1);
    ck("crlf_count", 5, far_u.rx_q.size());
    for (j = 0; j < 5; j++) begin
      ck_tx(j, (j == 2 || j == 4) ? `KKIL_C_LF : `KKIL_C_CR);
    end
    // Top-row keys in every mode
    for (m = 0; m < 4; m++) begin
      apb(1, `KKIL_CTRL_OFF, (m << 5) | 32'h06);
      clr();
      for (j = 0; j < 3; j++) key(8'(`KKIL_K_F11 + j), 1);
      ck("top_row_count", 3, far_u.rx_q.size());
      for (j = 0; j < 3; j++) begin
        ck_tx(j, (m < 2) ? lg[j] : 8'(`KKIL_K_F11 + j));
      end
    end
    // Lock toggles, letters forced upper
    apb(1, `KKIL_CTRL_OFF, 32'h46);
    key(`KKIL_K_LOCK, 1);
    ck("lamp_lock", 1, lamp_lock);
    apb(0, `KKIL_STAT_OFF, 0);
    ck("stat_lock", 32'h01, rd);
    clr();
    key(8'h62, 1);
    ck_tx(0, 8'h42);
    key(`KKIL_K_LOCK, 1);
    ck("lamp_lock_off", 0, lamp_lock);
    // Lock set to shift every key: digit one gives its shifted value
    apb(1, `KKIL_CTRL_OFF, 32'h47);
    key(`KKIL_K_LOCK, 1);
    clr();
    key(8'h31, 1);
    ck_tx(0, 8'h21);
    key(`KKIL_K_LOCK, 1);
    ck("lamp_lock_all_off", 0, lamp_lock);
    // Freeze holds back host characters
    key(`KKIL_K_FREEZE, 1);
    ck("lamp_freeze", 1, lamp_freeze);
    clr();
    far_u.send(8'h41, 4);
    ck("frozen_show", 0, cnt[2]);
    key(`KKIL_K_FREEZE, 1);
    ck("lamp_freeze_off", 0, lamp_freeze);
    clr();
    far_u.send(8'h5A, 0);
    far_u.send(`KKIL_C_BEL, 4);
    ck("show_count", 2, cnt[2]);
    ck("show_char", 32'h07, show_char);
    ck("host_bell", 1, cnt[1]);
    // Compose: error with equal characters, then a valid pair
    key(`KKIL_K_COMPOSE, 1);
    ck("lamp_compose", 1, lamp_compose);
    clr();
    key(8'h61, 1); key(8'h61, 1);
    ck("compose_err_bell", 1, cnt[1]);
    ck("compose_err_tx", 0, far_u.rx_q.size());
    ck("lamp_compose_off", 0, lamp_compose);
    key(`KKIL_K_COMPOSE, 1); key(8'h61, 1); key(8'h65, 1);
    ck_tx(0, 8'h84);
    // Margin bell enabled, then disabled
    clr();
    far_u.margin();
    ck("margin_bell", 1, cnt[1]);
    apb(1, `KKIL_CTRL_OFF, 32'h42);
    clr();
    far_u.margin();
    ck("margin_bell_off", 0, cnt[1]);
    // Click disabled, then an inactive key
    apb(1, `KKIL_CTRL_OFF, 32'h40);
    clr();
    key(8'h61, 1);
    ck("click_disabled", 0, cnt[0]);
    apb(1, `KKIL_CTRL_OFF, 32'h46);
    key(8'h90, 1);
    ck("click_inactive", 0, cnt[0]);
    // Keyboard blocked: wait lamp, keys lost, silent
    far_u.set_block(1'b1);
    ck("lamp_wait", 1, lamp_wait);
    clr();
    key(8'h61, 1);
    ck("wait_click", 0, cnt[0]);
    ck("wait_tx", 0, far_u.rx_q.size());
    far_u.set_block(1'b0);
    ck("lamp_wait_off", 0, lamp_wait);
    // Break disabled, enabled, with shift and with control
    clr();
    key(`KKIL_K_BREAK, 1);
    ck("break_off", 0, cnt[3]);
    apb(1, `KKIL_CTRL_OFF, 32'h56);
    key(`KKIL_K_BREAK, 1);
    key(`KKIL_K_SHIFT, 1); key(`KKIL_K_BREAK, 1); key(`KKIL_K_PRINT, 1);
    key(`KKIL_K_SHIFT, 0); key(`KKIL_K_CTRL, 1); key(`KKIL_K_BREAK, 1);
    key(`KKIL_K_PRINT, 1); key(`KKIL_K_CTRL, 0); key(`KKIL_K_PRINT, 1);
    key(`KKIL_K_HANDOVER, 1);
    ck("handover", 1, cnt[8]);
    ck("break_on", 1, cnt[3]);
    ck("disconnect", 1, cnt[4]);
    ck("answerback", 1, cnt[5]);
    ck("print_text", 1, cnt[6]);
    ck("print_image", 1, cnt[7]);
    ck("autoprint", 1, autoprint);
    // Configuration state holds host data
    key(`KKIL_K_SETUP, 1);
    ck("setup_on", 1, setup_state);
    clr();
    far_u.send(8'h51, 4);
    ck("setup_show", 0, cnt[2]);
    ck("setup_hold", 1, host_hold);
    ck("setup_local", 1, tx_local);
    key(`KKIL_K_SETUP, 1);
    ck("setup_off", 0, setup_state);
    ck("setup_local_off", 0, tx_local);
    finish_test();
  end
endmodule
`default_nettype wire
